// ===== include/cmfc_cfg.svh
// Constants for the CAN mode and frame control block.
// Assumes inclusion once per compilation unit, before cmfc_pkg.
`ifndef CMFC_CFG_SVH
`define CMFC_CFG_SVH
// Mode codes for the requested and current mode fields
`define CMFC_MODE_NORMAL   3'h0
`define CMFC_MODE_DISABLE  3'h1
`define CMFC_MODE_LOOPBACK 3'h2
`define CMFC_MODE_LISTEN   3'h3
`define CMFC_MODE_INIT     3'h4
`define CMFC_MODE_ERRREC   3'h7
// Field positions in the module control and rx buffer control words
`define CMFC_REQUESTED_OP_FIELD_HI      10
`define CMFC_REQUESTED_OP_FIELD_LO      8
`define CMFC_CUROP_HI      7
`define CMFC_CUROP_LO      5
`define CMFC_RXM_HI        6
`define CMFC_RXM_LO        5
// Receive match-select values; all selects error recognition in normal mode, std and ext the frame type
`define CMFC_RXM_ALL       2'h3
`define CMFC_RXM_STD       2'h1
`define CMFC_RXM_EXT       2'h2
// Configuration write addresses
`define CMFC_CA_MASK0      4'h6
`define CMFC_CA_MASK1      4'h7
`define CMFC_CA_BRP        4'h8
// Reset values
`define CMFC_RST_MODE      3'h4
`define CMFC_RST_BRP       6'h00
// Timing
`define CMFC_CLK_HZ        40000000
`define CMFC_MAX_BPS       1000000
`define CMFC_MIN_BIT_CYC   (`CMFC_CLK_HZ / `CMFC_MAX_BPS)
`define CMFC_IDLE_BITS     4'hb
`define CMFC_IFS_BITS      4'h3
`define CMFC_MAX_OVL       2'h2
`define CMFC_MAX_DLC       4'h8
`endif

// ===== include/cmfc_pkg.sv
// Types for the CAN mode and frame control block.
// Assumes cmfc_cfg.svh is compiled first.
`default_nettype none
package cmfc_pkg;
  typedef enum logic [2:0] {
    CMFC_NORMAL   = 3'h0,
    CMFC_DISABLE  = 3'h1,
    CMFC_LOOPBACK = 3'h2,
    CMFC_LISTEN   = 3'h3,
    CMFC_INIT     = 3'h4
  } cmfc_mode_t;

  typedef struct packed {
    cmfc_mode_t        mode;
    logic [2:0]        cur_op;
    logic [3:0]        rec_cnt;
    logic [11:0]       div_cnt;
    logic              bit_en;
    logic [5:0]        brp;
    logic [5:0][28:0]  fid;
    logic [5:0]        fide;
    logic [1:0][28:0]  mask;
    logic [7:0]        tec;
    logic [7:0]        rec;
    logic [1:0]        rx_full;
    logic [1:0]        rx_ovr;
    logic [2:0]        tx_pend;
    logic [2:0]        tx_abt;
    logic              tx_start;
    logic [1:0]        tx_sel;
    logic              err_frame;
    logic              ovl_frame;
    logic [1:0]        ovl_cnt;
    logic              cfg_refused;
  } cmfc_state_t;
endpackage
`default_nettype wire

// ===== core/cmfc_rx_mem.sv
// Two-entry receive message store: identifier, flags, length, data.
// Assumes one writer; read data is registered one cycle after address.
`default_nettype none
module cmfc_rx_mem (
  input  wire logic        i_mclk,
  input  wire logic        i_we,
  input  wire logic        i_waddr,
  input  wire logic [98:0] i_wdata,
  input  wire logic        i_raddr,
  output logic      [98:0] o_rdata
);
  logic [98:0] mem_reg [2];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_raddr];
  end
endmodule // cmfc_rx_mem
`default_nettype wire

// ===== core/cmfc_ctrl.sv
// CAN mode and frame control: mode changes, config lock, filters, tx pick.
// Assumes a protocol engine outside that shifts bits and reports events.
`default_nettype none
`include "cmfc_cfg.svh"
module cmfc_ctrl (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [2:0]  i_requested_op_field,
  input  wire logic [1:0]  i_receive_match_select0,
  input  wire logic [1:0]  i_receive_match_select1,
  input  wire logic        i_cfg_we,
  input  wire logic [3:0]  i_cfg_addr,
  input  wire logic [29:0] i_cfg_data,
  input  wire logic        i_bus_rx,
  input  wire logic        i_tx_busy,
  input  wire logic        i_bus_err,
  input  wire logic        i_tx_err,
  input  wire logic        i_ifs_dominant,
  input  wire logic        i_not_ready,
  input  wire logic        i_sof,
  input  wire logic        i_rx_done,
  input  wire logic        i_rx_crc_ok,
  input  wire logic [10:0] i_base_identifier,
  input  wire logic [17:0] i_identifier_extension,
  input  wire logic        i_rx_ide,
  input  wire logic        i_rx_rtr,
  input  wire logic [3:0]  i_rx_dlc,
  input  wire logic [63:0] i_rx_data,
  input  wire logic [1:0]  i_rx_release,
  input  wire logic        i_rd_buf,
  input  wire logic [2:0]  i_tx_req,
  input  wire logic [5:0]  i_tx_prio,
  input  wire logic [2:0]  i_tx_abort,
  input  wire logic        i_tx_sent,
  output logic      [2:0]  o_current_op_field,
  output logic             o_bit_en,
  output logic             o_tx_en,
  output logic             o_rx_en,
  output logic             o_tx_start,
  output logic      [1:0]  o_tx_sel,
  output logic      [2:0]  o_tx_pend,
  output logic      [2:0]  o_tx_abt,
  output logic             o_err_frame,
  output logic             o_ovl_frame,
  output logic      [7:0]  o_tec,
  output logic      [7:0]  o_rec,
  output logic      [1:0]  o_rx_full,
  output logic      [1:0]  o_rx_ovr,
  output logic             o_cfg_refused,
  output logic      [98:0] o_rd_data
);
  cmfc_pkg::cmfc_state_t st_reg;
  cmfc_pkg::cmfc_state_t st_next;
  logic                  mem_we;
  logic                  mem_waddr;
  logic [98:0]           mem_wdata;
  logic                  tx_en_reg;
  logic                  rx_en_reg;

  function automatic logic filt_hit(
    input logic [28:0] id,
    input logic        ide,
    input logic [28:0] fid,
    input logic        fide,
    input logic [28:0] msk,
    input logic [1:0]  receive_match_select
  );
    logic ide_ok;
    ide_ok = 1'b0;
    // Match select 01 or 10 overrides the filter's frame-type bit
    unique case (receive_match_select)
      `CMFC_RXM_STD: ide_ok = !ide;
      `CMFC_RXM_EXT: ide_ok = ide;
      default:       ide_ok = (ide == fide);
    endcase
    filt_hit = ide_ok && (((id ^ fid) & msk) == 29'h0000000);
  endfunction

  function automatic logic [1:0] tx_pick(
    input logic [2:0] pend,
    input logic [5:0] prio
  );
    logic [1:0] best;
    logic [1:0] bp;
    best = 2'h3;
    bp   = 2'h0;
    // Higher value wins; equal priority goes to the lower index
    for (int i = 0; i < 3; i++) begin
      if (pend[i] && (best == 2'h3 || prio[2*i +: 2] > bp)) begin
        best = 2'(i);
        bp   = prio[2*i +: 2];
      end
    end
    tx_pick = best;
  endfunction

  logic [28:0] rx_id;
  logic [1:0]  rxm_any_all;
  logic        err_rec;
  logic [3:0]  dlc_lim;
  logic        hit0;
  logic        hit1;
  logic        rx_good;
  logic [1:0]  pick;
  logic        idle;
  logic        ifs_ok;
  logic [11:0] bit_cyc;

  always_comb begin
    rx_id = {i_base_identifier, i_identifier_extension};
    if (!i_rx_ide) begin
      // Standard frames carry only the 11-bit base identifier
      rx_id = {i_base_identifier, 18'h00000};
    end
    rxm_any_all = {i_receive_match_select1 == `CMFC_RXM_ALL,
                   i_receive_match_select0 == `CMFC_RXM_ALL};
    err_rec = (rxm_any_all != 2'h0)
              && (st_reg.mode == cmfc_pkg::CMFC_NORMAL);
    dlc_lim = (i_rx_dlc > `CMFC_MAX_DLC) ? `CMFC_MAX_DLC : i_rx_dlc;
    hit0 = rxm_any_all[0];
    hit1 = rxm_any_all[1];
    for (int f = 0; f < 2; f++) begin
      hit0 = hit0 | filt_hit(rx_id, i_rx_ide, st_reg.fid[f],
                             st_reg.fide[f], st_reg.mask[0],
                             i_receive_match_select0);
    end
    for (int f = 2; f < 6; f++) begin
      hit1 = hit1 | filt_hit(rx_id, i_rx_ide, st_reg.fid[f],
                             st_reg.fide[f], st_reg.mask[1],
                             i_receive_match_select1);
    end
    // Error-recognition keeps even damaged frames
    rx_good = i_rx_done && rx_en_reg && (i_rx_crc_ok || err_rec);
    pick = tx_pick(st_reg.tx_pend, i_tx_prio);
    idle = (st_reg.rec_cnt >= `CMFC_IDLE_BITS);
    ifs_ok = (st_reg.rec_cnt >= `CMFC_IFS_BITS);
    bit_cyc = (12'({st_reg.brp, 1'b0}) + 12'h002)
              * 12'(`CMFC_MIN_BIT_CYC / 2);
  end

  assign tx_en_reg = (st_reg.mode == cmfc_pkg::CMFC_NORMAL)
                     || (st_reg.mode == cmfc_pkg::CMFC_LOOPBACK);
  assign rx_en_reg = (st_reg.mode != cmfc_pkg::CMFC_INIT)
                     && (st_reg.mode != cmfc_pkg::CMFC_DISABLE);

  always_comb begin
    st_next             = st_reg;
    st_next.bit_en      = 1'b0;
    st_next.tx_start    = 1'b0;
    st_next.err_frame   = 1'b0;
    st_next.ovl_frame   = 1'b0;
    st_next.cfg_refused = 1'b0;
    st_next.tx_abt      = 3'h0;
    mem_we              = 1'b0;
    mem_waddr           = 1'b0;
    mem_wdata           = {rx_id, i_rx_ide, i_rx_rtr, dlc_lim,
                           i_rx_data};

    // Bit-rate enable; brp 0 gives the fastest 1 Mbit/s bit time
    if (st_reg.div_cnt == 12'h000) begin
      st_next.div_cnt = bit_cyc - 12'h001;
      st_next.bit_en  = 1'b1;
      if (!i_bus_rx) begin
        st_next.rec_cnt = 4'h0;
      end else if (!idle) begin
        st_next.rec_cnt = st_reg.rec_cnt + 4'h1;
      end
    end else begin
      st_next.div_cnt = st_reg.div_cnt - 12'h001;
    end

    // Mode change only on an idle bus; init also waits for tx end
    if ((i_requested_op_field != st_reg.mode) && idle) begin
      unique case (i_requested_op_field)
        `CMFC_MODE_NORMAL:   st_next.mode = cmfc_pkg::CMFC_NORMAL;
        `CMFC_MODE_DISABLE:  st_next.mode = cmfc_pkg::CMFC_DISABLE;
        `CMFC_MODE_LOOPBACK: st_next.mode = cmfc_pkg::CMFC_LOOPBACK;
        `CMFC_MODE_LISTEN:   st_next.mode = cmfc_pkg::CMFC_LISTEN;
        `CMFC_MODE_INIT: begin
          if (!i_tx_busy) begin
            st_next.mode = cmfc_pkg::CMFC_INIT;
          end
        end
        default: st_next.mode = st_reg.mode;
      endcase
    end
    st_next.cur_op = err_rec ? `CMFC_MODE_ERRREC
                             : 3'(st_reg.mode);

    // Error counting; entry to init wipes both counters
    if (rx_en_reg && i_bus_err && st_reg.rec != 8'hff) begin
      st_next.rec = st_reg.rec + 8'h01;
    end
    if (tx_en_reg && i_tx_err && st_reg.tec != 8'hff) begin
      st_next.tec = st_reg.tec + 8'h01;
    end
    if (st_next.mode == cmfc_pkg::CMFC_INIT
        && st_reg.mode != cmfc_pkg::CMFC_INIT) begin
      st_next.tec = 8'h00;
      st_next.rec = 8'h00;
    end

    // Listen-only stays passive on the bus
    if (i_bus_err && rx_en_reg && st_reg.mode != cmfc_pkg::CMFC_LISTEN
        && !err_rec) begin
      st_next.err_frame = 1'b1;
    end
    if (i_sof) begin
      st_next.ovl_cnt = 2'h0;
    end else if ((i_ifs_dominant || i_not_ready) && rx_en_reg
                 && st_reg.mode != cmfc_pkg::CMFC_LISTEN) begin
      if (st_reg.ovl_cnt < `CMFC_MAX_OVL) begin
        st_next.ovl_frame = 1'b1;
        st_next.ovl_cnt   = st_reg.ovl_cnt + 2'h1;
      end
    end

    // Configuration lock
    if (i_cfg_we) begin
      if (st_reg.mode != cmfc_pkg::CMFC_INIT) begin
        st_next.cfg_refused = 1'b1;
      end else if (i_cfg_addr < `CMFC_CA_MASK0) begin
        st_next.fid[i_cfg_addr[2:0]]  = i_cfg_data[28:0];
        st_next.fide[i_cfg_addr[2:0]] = i_cfg_data[29];
      end else if (i_cfg_addr == `CMFC_CA_MASK0) begin
        st_next.mask[0] = i_cfg_data[28:0];
      end else if (i_cfg_addr == `CMFC_CA_MASK1) begin
        st_next.mask[1] = i_cfg_data[28:0];
      end else if (i_cfg_addr == `CMFC_CA_BRP) begin
        st_next.brp = i_cfg_data[5:0];
      end else begin
        st_next.cfg_refused = 1'b1;
      end
    end

    // Receive store; buffer 0 has priority, full means overrun
    for (int b = 0; b < 2; b++) begin
      if (i_rx_release[b]) begin
        st_next.rx_full[b] = 1'b0;
        st_next.rx_ovr[b]  = 1'b0;
      end
    end
    if (rx_good && (hit0 || hit1)) begin
      mem_waddr = !hit0;
      if (st_reg.rx_full[mem_waddr]) begin
        st_next.rx_ovr[mem_waddr] = 1'b1;
      end else begin
        // Set wins over a release in the same cycle
        mem_we                     = 1'b1;
        st_next.rx_full[mem_waddr] = 1'b1;
      end
    end

    // Transmit buffers: request, abort, pick, start after IFS
    if (i_tx_sent) begin
      st_next.tx_pend[st_reg.tx_sel] = 1'b0;
    end
    for (int t = 0; t < 3; t++) begin
      if (i_tx_abort[t] && st_reg.tx_pend[t]
          && !(i_tx_busy && st_reg.tx_sel == 2'(t))) begin
        st_next.tx_pend[t] = 1'b0;
        st_next.tx_abt[t]  = 1'b1;
      end
      if (i_tx_req[t]) begin
        st_next.tx_pend[t] = 1'b1;
      end
    end
    if (st_reg.mode == cmfc_pkg::CMFC_DISABLE) begin
      st_next.tx_abt  = st_reg.tx_pend;
      st_next.tx_pend = 3'h0;
    end
    if (tx_en_reg && !i_tx_busy && !st_reg.tx_start && ifs_ok
        && pick != 2'h3 && !i_tx_abort[pick]) begin
      st_next.tx_start = 1'b1;
      st_next.tx_sel   = pick;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg         <= '0;
      st_reg.mode    <= cmfc_pkg::cmfc_mode_t'(`CMFC_RST_MODE);
      st_reg.cur_op  <= `CMFC_RST_MODE;
      st_reg.brp     <= `CMFC_RST_BRP;
      st_reg.tx_sel  <= 2'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  cmfc_rx_mem u_rx_mem (
    .i_mclk  (i_mclk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (i_rd_buf),
    .o_rdata (o_rd_data)
  );

  logic tx_en_q;
  logic rx_en_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else begin
      tx_en_q <= (st_next.mode == cmfc_pkg::CMFC_NORMAL)
                 || (st_next.mode == cmfc_pkg::CMFC_LOOPBACK);
      rx_en_q <= (st_next.mode != cmfc_pkg::CMFC_INIT)
                 && (st_next.mode != cmfc_pkg::CMFC_DISABLE);
    end
  end

  assign o_current_op_field = st_reg.cur_op;
  assign o_bit_en           = st_reg.bit_en;
  assign o_tx_en            = tx_en_q;
  assign o_rx_en            = rx_en_q;
  assign o_tx_start         = st_reg.tx_start;
  assign o_tx_sel           = st_reg.tx_sel;
  assign o_tx_pend          = st_reg.tx_pend;
  assign o_tx_abt           = st_reg.tx_abt;
  assign o_err_frame        = st_reg.err_frame;
  assign o_ovl_frame        = st_reg.ovl_frame;
  assign o_tec              = st_reg.tec;
  assign o_rec              = st_reg.rec;
  assign o_rx_full          = st_reg.rx_full;
  assign o_rx_ovr           = st_reg.rx_ovr;
  assign o_cfg_refused      = st_reg.cfg_refused;
endmodule // cmfc_ctrl
`default_nettype wire

// ===== testbench/cmfc_monitor.sv
// Checker for the CAN mode and frame control block.
// Assumes it sees only the ports of cmfc_ctrl, bound below.
`default_nettype none
module cmfc_monitor (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_cfg_we,
  input wire logic       i_bus_rx,
  input wire logic       i_tx_busy,
  input wire logic       i_bus_err,
  input wire logic       i_sof,
  input wire logic [2:0] o_current_op_field,
  input wire logic       o_bit_en,
  input wire logic       o_tx_en,
  input wire logic       o_tx_start,
  input wire logic [2:0] o_tx_pend,
  input wire logic [2:0] o_tx_abt,
  input wire logic       o_err_frame,
  input wire logic       o_ovl_frame,
  input wire logic [7:0] o_tec,
  input wire logic [7:0] o_rec,
  input wire logic       o_cfg_refused
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [3:0] idle_n;
  logic [1:0] ovl_n;
  logic       bus_rx_reg;
  // Bus level as the block saw it at its bit tick; count trails by one cycle
  always_ff @(posedge i_mclk) begin
    bus_rx_reg <= i_bus_rx;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst || (o_bit_en && !bus_rx_reg)) idle_n <= 4'h0;
    else if (o_bit_en && idle_n != 4'hb) idle_n <= idle_n + 4'h1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_sof) ovl_n <= 2'h0;
    else if (o_ovl_frame && ovl_n != 2'h3) ovl_n <= ovl_n + 2'h1;
  end
  property p_hold;
    o_current_op_field != $past(o_current_op_field) &&
    o_current_op_field != 3'h7 && $past(o_current_op_field) != 3'h7
    |-> $past(idle_n) == 4'hb;
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode changed on busy bus");
  property p_refuse;
    o_cfg_refused |-> $past(i_cfg_we);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refusal without write");
  property p_start;
    o_tx_start |-> o_tx_en && $past(o_tx_en) && !$past(i_tx_busy)
      ##1 !o_tx_start;
  endproperty
  a_start: assert property (p_start)
    else $error("bad transmit start");
  property p_err;
    o_err_frame |-> $past(i_bus_err);
  endproperty
  a_err: assert property (p_err)
    else $error("error frame without cause");
  property p_rec;
    o_err_frame && $past(o_rec) != 8'hff |-> o_rec == $past(o_rec) + 8'h1;
  endproperty
  a_rec: assert property (p_rec)
    else $error("receive count not stepped");
  property p_clr;
    $changed(o_current_op_field) && o_current_op_field == 3'h4
    |-> o_tec == 8'h0 && o_rec == 8'h0;
  endproperty
  a_clr: assert property (p_clr)
    else $error("counters kept in init");
  property p_ovl;
    o_ovl_frame |-> ovl_n < 2'h2;
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("third overload frame");
  property p_abt;
    o_tx_abt != 3'h0 |-> ($past(o_tx_pend) & o_tx_abt) == o_tx_abt;
  endproperty
  a_abt: assert property (p_abt)
    else $error("abort of idle buffer");
endmodule // cmfc_monitor
bind cmfc_ctrl cmfc_monitor u_mon (.i_mclk, .i_rst, .i_cfg_we, .i_bus_rx,
  .i_tx_busy, .i_bus_err, .i_sof, .o_current_op_field, .o_bit_en, .o_tx_en,
  .o_tx_start, .o_tx_pend, .o_tx_abt, .o_err_frame, .o_ovl_frame, .o_tec,
  .o_rec, .o_cfg_refused);
`default_nettype wire

// ===== testbench/cmfc_can_node.sv
// Model of the other nodes on the bus, as seen through the engine.
// Assumes the bench calls send and drives i_talk after a clock edge.
`default_nettype none
module cmfc_can_node (
  input  wire logic        i_mclk,
  input  wire logic        i_talk,
  output logic             o_bus_rx,
  output logic             o_done,
  output logic             o_crc_ok,
  output logic      [10:0] o_base,
  output logic      [17:0] o_ext,
  output logic             o_ide,
  output logic             o_rtr,
  output logic      [3:0]  o_dlc,
  output logic      [63:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // A talking node holds the bus dominant; a quiet bus is recessive
  assign o_bus_rx = !i_talk;
  initial {o_done, o_crc_ok, o_base, o_ext, o_ide, o_rtr, o_dlc, o_data} = '0;
  task automatic send(input logic [28:0] id, input logic ide, input logic rtr,
                      input logic [3:0] dlc, input logic [63:0] d);
    @(posedge i_mclk);
    #1;
    {o_base, o_ext} = id;
    {o_ide, o_rtr, o_dlc, o_data} = {ide, rtr, dlc, d};
    {o_done, o_crc_ok} = 2'h3;
    @(posedge i_mclk);
    #1;
    o_done = 1'b0;
    // Identifier and data mean nothing outside the pulse, so do not leave them steady
    {o_base, o_ext, o_data} = ~{o_base, o_ext, o_data};
  endtask
endmodule // cmfc_can_node
`default_nettype wire

// ===== testbench/cmfc_ctrl_tb.sv
// Self-checking bench for cmfc_ctrl with a bus node model.
// Assumes a 40 MHz clock and the mode codes of the package.
`default_nettype none
`include "cmfc_cfg.svh"
module cmfc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk, i_rst, i_cfg_we, i_bus_rx, i_tx_busy, i_bus_err, i_tx_err;
  logic i_ifs_dominant, i_not_ready, i_sof, i_rx_done, i_rx_crc_ok, i_rx_ide;
  logic i_rx_rtr, i_rd_buf, i_tx_sent, o_bit_en, o_tx_en, o_rx_en, talk;
  logic o_tx_start, o_err_frame, o_ovl_frame, o_cfg_refused;
  logic [1:0] i_receive_match_select0, i_receive_match_select1, i_rx_release;
  logic [1:0] o_tx_sel, o_rx_full, o_rx_ovr;
  logic [2:0] i_requested_op_field, i_tx_req, i_tx_abort, o_current_op_field;
  logic [2:0] o_tx_pend, o_tx_abt;
  logic [3:0] i_cfg_addr, i_rx_dlc;
  logic [5:0] i_tx_prio;
  logic [7:0] o_tec, o_rec;
  logic [10:0] i_base_identifier;
  logic [17:0] i_identifier_extension;
  logic [29:0] i_cfg_data;
  logic [63:0] i_rx_data;
  logic [98:0] o_rd_data;
  int error_cnt, n_tests, n;
  cmfc_ctrl dut (.i_mclk, .i_rst, .i_requested_op_field,
    .i_receive_match_select0, .i_receive_match_select1, .i_cfg_we,
    .i_cfg_addr, .i_cfg_data, .i_bus_rx, .i_tx_busy, .i_bus_err, .i_tx_err,
    .i_ifs_dominant, .i_not_ready, .i_sof, .i_rx_done, .i_rx_crc_ok,
    .i_base_identifier, .i_identifier_extension, .i_rx_ide, .i_rx_rtr,
    .i_rx_dlc, .i_rx_data, .i_rx_release, .i_rd_buf, .i_tx_req, .i_tx_prio,
    .i_tx_abort, .i_tx_sent, .o_current_op_field, .o_bit_en, .o_tx_en,
    .o_rx_en, .o_tx_start, .o_tx_sel, .o_tx_pend, .o_tx_abt, .o_err_frame,
    .o_ovl_frame, .o_tec, .o_rec, .o_rx_full, .o_rx_ovr, .o_cfg_refused,
    .o_rd_data);
  cmfc_can_node node (.i_mclk, .i_talk(talk), .o_bus_rx(i_bus_rx),
    .o_done(i_rx_done), .o_crc_ok(i_rx_crc_ok), .o_base(i_base_identifier),
    .o_ext(i_identifier_extension), .o_ide(i_rx_ide), .o_rtr(i_rx_rtr),
    .o_dlc(i_rx_dlc), .o_data(i_rx_data));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [98:0] got, input logic [98:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask
  // Bounded wait: a mode that never shows ends the run
  task automatic wait_op(input logic [2:0] m);
    int k;
    i_requested_op_field = m;
    for (k = 0; k < 2000 && o_current_op_field !== m; k++) tick(1);
    chk(o_current_op_field, m);
    if (k == 2000) report_and_stop();
  endtask
  task automatic cfg(input logic [3:0] a, input logic r);
    {i_cfg_addr, i_cfg_data, i_cfg_we} = {a, 30'h2aaaaaaa, 1'b1};
    tick(1);
    i_cfg_we = 1'b0;
    chk(o_cfg_refused, r);
    // Let an edge pass so a following write does not retoggle the strobe
    tick(1);
  endtask
  task automatic t_modes();
    chk({o_current_op_field, o_tx_en, o_rx_en}, 5'h10);
    cfg(`CMFC_CA_MASK0, 1'b0);
    cfg(4'h9, 1'b1);
    wait_op(cmfc_pkg::CMFC_NORMAL);
    chk({o_tx_en, o_rx_en}, 2'h3);
    cfg(`CMFC_CA_BRP, 1'b1);
    talk = 1'b1;
    // The idle count is saturated; let one bit tick see the busy bus first
    tick(50);
    i_requested_op_field = cmfc_pkg::CMFC_LISTEN;
    tick(600);
    chk(o_current_op_field, cmfc_pkg::CMFC_NORMAL);
    talk = 1'b0;
    wait_op(cmfc_pkg::CMFC_LISTEN);
    wait_op(cmfc_pkg::CMFC_LOOPBACK);
    wait_op(cmfc_pkg::CMFC_NORMAL);
  endtask
  task automatic t_rx();
    i_receive_match_select0 = 2'h3;
    tick(2);
    chk(o_current_op_field, `CMFC_MODE_ERRREC);
    node.send({11'h5a5, 18'h0}, 1'b0, 1'b0, 4'h9, 64'h1122);
    chk(o_rx_full, 2'h1);
    tick(1);
    chk(o_rd_data[98:64], {11'h5a5, 18'h0, 6'h08});
    node.send(29'h1abcdef0, 1'b1, 1'b1, 4'h2, 64'h0);
    chk(o_rx_ovr, 2'h1);
    i_rx_release = 2'h1;
    tick(1);
    i_rx_release = 2'h0;
    node.send(29'h1abcdef0, 1'b1, 1'b1, 4'h2, 64'h55);
    tick(1);
    chk(o_rd_data, {29'h1abcdef0, 6'h32, 64'h55});
    i_receive_match_select0 = 2'h0;
    tick(2);
    chk(o_current_op_field, cmfc_pkg::CMFC_NORMAL);
    i_rx_release = 2'h1;
    tick(1);
    i_rx_release = 2'h0;
    // Mask 0 has only odd identifier bits set
    node.send({11'h555, 18'h0}, 1'b0, 1'b0, 4'h1, 64'h0);
    chk(o_rx_full, 2'h1);
    node.send({11'h2aa, 18'h0}, 1'b0, 1'b0, 4'h1, 64'h0);
    chk(o_rx_full, 2'h3);
    i_rd_buf = 1'b1;
    tick(1);
    chk(o_rd_data[98:70], {11'h2aa, 18'h0});
    {i_rd_buf, i_rx_release} = 3'h2;
    tick(1);
    i_rx_release = 2'h0;
  endtask
  task automatic t_err_ovl();
    for (n = 0; n < 100 && o_bit_en !== 1'b1; n++) tick(1);
    chk(o_bit_en, 1'b1);
    if (n == 100) report_and_stop();
    tick(39);
    chk(o_bit_en, 1'b0);
    tick(1);
    chk(o_bit_en, 1'b1);
    {i_bus_err, i_tx_err} = 2'h3;
    tick(1);
    {i_bus_err, i_tx_err} = 2'h0;
    chk({o_err_frame, o_rec, o_tec}, 17'h10101);
    n = 0;
    repeat (3) begin
      i_ifs_dominant = 1'b1;
      tick(1);
      {i_ifs_dominant, i_not_ready} = 2'h1;
      n += (o_ovl_frame === 1'b1);
      tick(1);
      i_not_ready = 1'b0;
      n += (o_ovl_frame === 1'b1);
      tick(1);
      n += (o_ovl_frame === 1'b1);
    end
    chk(n, 2);
    i_sof = 1'b1;
    tick(1);
    i_sof = 1'b0;
  endtask
  task automatic t_tx();
    int k;
    {i_tx_prio, i_tx_req} = {6'h30, 3'h6};
    tick(1);
    i_tx_req = 3'h0;
    for (k = 0; k < 500 && o_tx_start !== 1'b1; k++) tick(1);
    chk(o_tx_start, 1'b1);
    if (k == 500) report_and_stop();
    chk(o_tx_sel, 2'h2);
    i_tx_busy = 1'b1;
    i_tx_sent = 1'b1;
    tick(1);
    {i_tx_sent, i_tx_req} = 4'h1;
    tick(1);
    i_tx_req = 3'h0;
    tick(1);
    chk(o_tx_pend, 3'h3);
    i_tx_abort = 3'h1;
    tick(1);
    i_tx_abort = 3'h0;
    chk({o_tx_abt, o_tx_pend}, 6'h0a);
    wait_op(cmfc_pkg::CMFC_DISABLE);
    chk({o_tx_abt, o_tx_pend}, 6'h10);
    tick(1);
    chk(o_tx_pend, 3'h0);
    i_requested_op_field = cmfc_pkg::CMFC_INIT;
    tick(600);
    chk(o_current_op_field, cmfc_pkg::CMFC_DISABLE);
    i_tx_busy = 1'b0;
    wait_op(cmfc_pkg::CMFC_INIT);
    chk({o_tec, o_rec, o_rx_full}, 18'h1);
  endtask
  initial begin
    {i_rst, i_requested_op_field, i_rd_buf} = 5'h18;
    {i_cfg_we, i_tx_busy, i_bus_err, i_tx_err, i_ifs_dominant} = '0;
    {i_not_ready, i_sof, i_tx_sent, talk, i_rx_release} = '0;
    {i_receive_match_select0, i_receive_match_select1} = '0;
    {i_cfg_addr, i_cfg_data, i_tx_req, i_tx_prio, i_tx_abort} = '0;
    error_cnt = 0;
    n_tests = 0;
    tick(20);
    i_rst = 1'b0;
    t_modes();
    t_rx();
    t_err_ovl();
    t_tx();
    report_and_stop();
  end
endmodule // cmfc_ctrl_tb
`default_nettype wire
